/* File: rtl/fbbb_bridge.sv */
// Flash burst bus bridge: access controller, burst counter, chip-select tracker
//
// Summary of operation
// - Read starts on strobe; counter loads A3:2.
// - Address-valid at N=2; idle if unselected.
// - Default mode: one address-valid, then hold.
// - Output enable falls on negedge after N=2.
// - Default latency four: data valid at N=7.
// - Clock after last: idle, output enable off.
// - Fast mode: four addresses latched N=2..5.
// - Fast latency two: first data at N=5.
// - Strobe right after last re-enters read.
// - Chip select held until last without strobe.
// - Pipelined flash access holds select until next last.
// - Chip select held one extra clock after last.
// - Write starts on strobe; counter loads A3:2.
// - Write strobe negedge after N=1, two clocks.
// - Default write waits for last, then idle.
// - Fast write: increment at N=4, strobe again.
// - Counter on rising edges, write strobe falling.
// - Fast mode low after reset until configured.
// - Counter drives low flash address bits.
// - Address-valid tells flash to latch address.
`timescale 1ns/1ps
`default_nettype none

module fbbb_bridge (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic address_strobe_n_i,
	input wire logic burst_last_n_i,
	input wire logic write_not_read_i,
	input wire logic flash_hit_i,
	input wire logic [fbbb_pkg::CNT_W-1:0] addr_low_i,
	input wire logic fast_mode_i,
	output logic address_valid_n_o,
	output logic output_enable_n_o,
	output logic write_enable_n_o,
	output logic [fbbb_pkg::CNT_W-1:0] burst_low_count_o,
	output logic chip_select_n_o
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [fbbb_pkg::CNT_W-1:0] cnt_inc(
		input logic [fbbb_pkg::CNT_W-1:0] v
	);
		// Natural overflow keeps the burst inside its four-word group
		cnt_inc = v + fbbb_pkg::CNT_STEP;
	endfunction

	function automatic logic new_access(input logic ads_n, input logic hit);
		new_access = !ads_n && hit;
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	fbbb_pkg::fbbb_state_t state_r;
	fbbb_pkg::fbbb_state_t state_nxt;
	logic [fbbb_pkg::CNT_W-1:0] cnt_r;
	logic [fbbb_pkg::CNT_W-1:0] cnt_nxt;
	logic [fbbb_pkg::CNT_W-1:0] adv_cnt_r;
	logic [fbbb_pkg::CNT_W-1:0] adv_cnt_nxt;
	logic burst_last_n_seen_r;
	logic burst_last_n_seen_nxt;
	fbbb_pkg::fbbb_cs_t cs_r;
	fbbb_pkg::fbbb_cs_t cs_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic we_n_r;
	logic we_n_nxt;
	logic cs_active;
	logic ads;
	logic burst_last_n;

	assign ads = !address_strobe_n_i;
	assign burst_last_n = !burst_last_n_i;
	assign cs_active = (cs_r != fbbb_pkg::CS_OFF);

	// ---------------------------------------------------------------
	// Access controller and burst counter
	// ---------------------------------------------------------------
	// fast_mode_i is expected low from reset until both ends are
	// configured; the controller simply follows its level.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		adv_cnt_nxt = adv_cnt_r;
		burst_last_n_seen_nxt = burst_last_n_seen_r;
		unique case (state_r)
			fbbb_pkg::ST_IDLE: begin
				// A strobe right after the last transfer lands here and
				// starts the next access without delay
				if (ads) begin
					cnt_nxt = addr_low_i;
					burst_last_n_seen_nxt = 1'b0;
					if (write_not_read_i) begin
						state_nxt = fbbb_pkg::ST_WR_LOAD;
					end else begin
						state_nxt = fbbb_pkg::ST_RD_LOAD;
					end
				end
			end
			fbbb_pkg::ST_RD_LOAD: begin
				adv_cnt_nxt = fbbb_pkg::ADV_CNT_RST;
				if (cs_active) begin
					state_nxt = fbbb_pkg::ST_RD_ADV;
				end else begin
					state_nxt = fbbb_pkg::ST_IDLE;
				end
			end
			fbbb_pkg::ST_RD_ADV: begin
				if (fast_mode_i && adv_cnt_r != fbbb_pkg::ADV_BURST_LAST) begin
					// Counter runs ahead so the flash never waits for an address
					cnt_nxt = cnt_inc(cnt_r);
					adv_cnt_nxt = cnt_inc(adv_cnt_r);
				end else if (burst_last_n) begin
					// A single-word fast read ends with the first data word
					state_nxt = fbbb_pkg::ST_IDLE;
				end else begin
					state_nxt = fbbb_pkg::ST_RD_HOLD;
				end
			end
			fbbb_pkg::ST_RD_HOLD: begin
				// Flash keeps driving data until the last transfer
				if (burst_last_n) begin
					state_nxt = fbbb_pkg::ST_IDLE;
				end
			end
			fbbb_pkg::ST_WR_LOAD: begin
				if (burst_last_n) begin
					burst_last_n_seen_nxt = 1'b1;
				end
				state_nxt = fbbb_pkg::ST_WR_PULSE;
			end
			fbbb_pkg::ST_WR_PULSE: begin
				if (burst_last_n) begin
					burst_last_n_seen_nxt = 1'b1;
				end
				state_nxt = fbbb_pkg::ST_WR_GAP;
			end
			fbbb_pkg::ST_WR_GAP: begin
				if (burst_last_n) begin
					burst_last_n_seen_nxt = 1'b1;
				end
				if (fast_mode_i) begin
					state_nxt = fbbb_pkg::ST_WR_TAIL;
				end else begin
					state_nxt = fbbb_pkg::ST_WR_HOLD;
				end
			end
			fbbb_pkg::ST_WR_TAIL: begin
				// N=4: first write done; next data follows from the processor
				if (burst_last_n || burst_last_n_seen_r) begin
					state_nxt = fbbb_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_inc(cnt_r);
					state_nxt = fbbb_pkg::ST_WR_LOAD;
				end
			end
			fbbb_pkg::ST_WR_HOLD: begin
				if (burst_last_n || burst_last_n_seen_r) begin
					state_nxt = fbbb_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = fbbb_pkg::ST_IDLE;
			end
		endcase
	end

	// Counter changes only on rising edges, well ahead of the write
	// strobe's falling-edge transition
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= fbbb_pkg::ST_IDLE;
			cnt_r <= fbbb_pkg::CNT_RST;
			adv_cnt_r <= fbbb_pkg::ADV_CNT_RST;
			burst_last_n_seen_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			adv_cnt_r <= adv_cnt_nxt;
			burst_last_n_seen_r <= burst_last_n_seen_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Falling-edge strobes
	// ---------------------------------------------------------------
	// Half a clock of extra setup for the flash; both strobes sample the
	// rising-edge state, so they lag it by half a period
	always_comb begin
		oe_n_nxt = !(state_r == fbbb_pkg::ST_RD_ADV || state_r == fbbb_pkg::ST_RD_HOLD);
		we_n_nxt = !(state_r == fbbb_pkg::ST_WR_LOAD || state_r == fbbb_pkg::ST_WR_PULSE);
	end

	always_ff @(negedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
		end else begin
			oe_n_r <= oe_n_nxt;
			we_n_r <= we_n_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Chip-select tracker
	// ---------------------------------------------------------------
	always_comb begin
		cs_nxt = cs_r;
		unique case (cs_r)
			fbbb_pkg::CS_OFF: begin
				if (new_access(address_strobe_n_i, flash_hit_i)) begin
					cs_nxt = fbbb_pkg::CS_ON;
				end
			end
			fbbb_pkg::CS_ON: begin
				if (burst_last_n && !ads) begin
					cs_nxt = fbbb_pkg::CS_EXTRA;
				end else if (burst_last_n && ads) begin
					// Pipelined access: stay on only if it is ours again
					if (flash_hit_i) begin
						cs_nxt = fbbb_pkg::CS_ON;
					end else begin
						cs_nxt = fbbb_pkg::CS_EXTRA;
					end
				end
			end
			fbbb_pkg::CS_EXTRA: begin
				// Flash drops data with select, so hold it one clock longer
				if (new_access(address_strobe_n_i, flash_hit_i)) begin
					cs_nxt = fbbb_pkg::CS_ON;
				end else begin
					cs_nxt = fbbb_pkg::CS_OFF;
				end
			end
			default: begin
				cs_nxt = fbbb_pkg::CS_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_r <= fbbb_pkg::CS_OFF;
		end else begin
			cs_r <= cs_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign address_valid_n_o = (state_r != fbbb_pkg::ST_RD_ADV);
	assign output_enable_n_o = oe_n_r;
	assign write_enable_n_o = we_n_r;
	assign burst_low_count_o = cnt_r;
	assign chip_select_n_o = !cs_active;

endmodule

`default_nettype wire

/* File: rtl/fbbb_pkg.sv */
// Shared constants and types for the flash burst bus bridge
package fbbb_pkg;

	// ---------------------------------------------------------------
	// Widths and reset values
	// ---------------------------------------------------------------
	localparam int CNT_W = 2;
	localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
	localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
	// Address-valid stays low this many extra clocks in fast mode (N=2..5)
	localparam logic [CNT_W-1:0] ADV_BURST_LAST = 2'h3;
	localparam logic [CNT_W-1:0] ADV_CNT_RST = 2'h0;

	// ---------------------------------------------------------------
	// Flash latency settings the bridge is timed for
	// ---------------------------------------------------------------
	localparam int LAT_DEFAULT = 4;
	localparam int LAT_FAST = 2;
	localparam int DATA_CYCLE_DEFAULT = 7;
	localparam int DATA_CYCLE_FAST = 5;

	// ---------------------------------------------------------------
	// Access controller states, Gray along the default read path and the fast write loop
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_RD_LOAD = 4'h1,
		ST_RD_ADV = 4'h3,
		ST_RD_HOLD = 4'h2,
		ST_WR_LOAD = 4'h6,
		ST_WR_PULSE = 4'h7,
		ST_WR_GAP = 4'h5,
		ST_WR_TAIL = 4'h4,
		ST_WR_HOLD = 4'hC
	} fbbb_state_t;

	// ---------------------------------------------------------------
	// Chip-select tracker states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		CS_OFF = 2'h0,
		CS_ON = 2'h1,
		CS_EXTRA = 2'h3
	} fbbb_cs_t;

endpackage

/* File: sim/fbbb_flash_model.sv */
// Flash side model: counts latched addresses and write pulses
`timescale 1ns/1ps
`default_nettype none
module fbbb_flash_model (
	input wire logic sys_clk_i,
	input wire logic address_valid_n_i,
	input wire logic write_enable_n_i,
	input wire logic chip_select_n_i,
	input wire logic [1:0] addr_i,
	output logic [7:0] latch_cnt_o,
	output logic [7:0] wr_cnt_o,
	output logic [1:0] rd_addr_o,
	output logic [1:0] wr_addr_o
);
	logic [7:0] latch_cnt = 8'h00;
	logic [7:0] wr_cnt = 8'h00;
	logic [1:0] rd_addr = 2'h0;
	logic [1:0] wr_addr = 2'h0;
	assign latch_cnt_o = latch_cnt;
	assign wr_cnt_o = wr_cnt;
	assign rd_addr_o = rd_addr;
	assign wr_addr_o = wr_addr;
	always @(posedge sys_clk_i) begin
		if (!address_valid_n_i && !chip_select_n_i) begin
			latch_cnt <= latch_cnt + 8'h01;
			rd_addr <= addr_i;
		end
	end
	// Data is taken as the strobe rises, so the address must still hold here
	always @(posedge write_enable_n_i) begin
		if (!chip_select_n_i) begin
			wr_cnt <= wr_cnt + 8'h01;
			wr_addr <= addr_i;
		end
	end
endmodule
`default_nettype wire

/* File: sim/fbbb_monitor.sv */
// Port-level checker for the flash burst bus bridge
`timescale 1ns/1ps
`default_nettype none
module fbbb_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic address_strobe_n_i,
	input wire logic burst_last_n_i,
	input wire logic write_not_read_i,
	input wire logic flash_hit_i,
	input wire logic [fbbb_pkg::CNT_W-1:0] addr_low_i,
	input wire logic fast_mode_i,
	input wire logic address_valid_n_o,
	input wire logic output_enable_n_o,
	input wire logic write_enable_n_o,
	input wire logic [fbbb_pkg::CNT_W-1:0] burst_low_count_o,
	input wire logic chip_select_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic idle;
	logic rd_go;
	assign idle = chip_select_n_o && output_enable_n_o && write_enable_n_o;
	assign rd_go = !address_strobe_n_i && !write_not_read_i && idle;
	a_count_load: assert property (!address_strobe_n_i && idle
		|=> burst_low_count_o == $past(addr_low_i)) else $error("count not loaded");
	a_read_adv: assert property (rd_go && flash_hit_i
		|-> ##2 !address_valid_n_o) else $error("address valid late");
	a_miss_idle: assert property (rd_go && !flash_hit_i
		|=> chip_select_n_o ##1 address_valid_n_o) else $error("unselected read ran");
	a_single_adv: assert property (!fast_mode_i && $fell(address_valid_n_o)
		|=> address_valid_n_o) else $error("address valid too long");
	a_fast_four: assert property (fast_mode_i && $fell(address_valid_n_o)
		|-> !address_valid_n_o[*4] ##1 address_valid_n_o) else $error("burst length");
	a_count_step: assert property (!address_valid_n_o && !$past(address_valid_n_o)
		|-> burst_low_count_o == 2'($past(burst_low_count_o) + 2'h1)) else $error("count step");
	a_oe_release: assert property (!output_enable_n_o && !burst_last_n_i
		|=> output_enable_n_o) else $error("output enable held");
	a_oe_start: assert property (rd_go && flash_hit_i
		|=> output_enable_n_o ##1 !output_enable_n_o) else $error("output enable timing");
	a_cs_pipe: assert property ((!chip_select_n_o && !burst_last_n_i && !address_strobe_n_i
		&& flash_hit_i) ##1 (burst_last_n_i && address_strobe_n_i)
		|=> !chip_select_n_o) else $error("pipelined select dropped");
	a_we_two: assert property ($fell(write_enable_n_o)
		|=> !write_enable_n_o ##1 write_enable_n_o) else $error("write pulse width");
	a_cs_take: assert property (!address_strobe_n_i && flash_hit_i && chip_select_n_o
		|=> !chip_select_n_o) else $error("select not taken");
	a_cs_extra: assert property ((!chip_select_n_o && !burst_last_n_i && address_strobe_n_i)
		##1 address_strobe_n_i |-> !chip_select_n_o ##1 chip_select_n_o) else $error("select tail");
endmodule
bind fbbb_bridge fbbb_monitor mon_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.address_strobe_n_i(address_strobe_n_i), .burst_last_n_i(burst_last_n_i),
	.write_not_read_i(write_not_read_i), .flash_hit_i(flash_hit_i), .addr_low_i(addr_low_i),
	.fast_mode_i(fast_mode_i), .address_valid_n_o(address_valid_n_o),
	.output_enable_n_o(output_enable_n_o), .write_enable_n_o(write_enable_n_o),
	.burst_low_count_o(burst_low_count_o), .chip_select_n_o(chip_select_n_o));
`default_nettype wire

/* File: sim/test_fbbb_bridge.sv */
// Self-checking bench for the flash burst bus bridge
`timescale 1ns/1ps
`default_nettype none
module test_fbbb_bridge;
	logic sys_clk_i, rst_n_i, strobe_n, last_n, wnr, hit, fast;
	logic adv_n, oe_n, we_n, cs_n;
	logic [1:0] addr, cnt, raddr, waddr;
	logic [7:0] lat, wrc;
	int n_errors = 0;
	int checked = 0;
	fbbb_bridge dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .address_strobe_n_i(strobe_n),
		.burst_last_n_i(last_n), .write_not_read_i(wnr), .flash_hit_i(hit), .addr_low_i(addr),
		.fast_mode_i(fast), .address_valid_n_o(adv_n), .output_enable_n_o(oe_n),
		.write_enable_n_o(we_n), .burst_low_count_o(cnt), .chip_select_n_o(cs_n));
	fbbb_flash_model flash_u (.sys_clk_i(sys_clk_i), .address_valid_n_i(adv_n),
		.write_enable_n_i(we_n), .chip_select_n_i(cs_n), .addr_i(cnt), .latch_cnt_o(lat),
		.wr_cnt_o(wrc), .rd_addr_o(raddr), .wr_addr_o(waddr));
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Last is left low on return so a following call gives a back-to-back strobe
	task automatic xfer(input logic w, input logic h, input logic [1:0] a, input int gap);
		@(negedge sys_clk_i);
		last_n = 1'b1;
		strobe_n = 1'b0;
		wnr = w;
		hit = h;
		addr = a;
		@(negedge sys_clk_i);
		strobe_n = 1'b1;
		repeat (gap) @(negedge sys_clk_i);
		last_n = 1'b0;
	endtask
	task automatic rest;
		@(negedge sys_clk_i);
		last_n = 1'b1;
		repeat (4) @(negedge sys_clk_i);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ---------
	// Sequence
	// ---------
	initial begin
		rst_n_i = 1'b0;
		strobe_n = 1'b1;
		last_n = 1'b1;
		wnr = 1'b0;
		hit = 1'b0;
		addr = 2'h0;
		fast = 1'b0;
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk({6'h00, cs_n, oe_n}, 8'h03);
		rst_n_i = 1'b1;
		xfer(1'b0, 1'b1, 2'h1, 6);
		rest;
		chk(lat, 8'h01);
		chk({6'h00, raddr}, 8'h01);
		xfer(1'b0, 1'b0, 2'h2, 3);
		rest;
		chk(lat, 8'h01);
		xfer(1'b1, 1'b1, 2'h3, 3);
		rest;
		chk(wrc, 8'h01);
		chk({6'h00, waddr}, 8'h03);
		// Set-up code is taken to have run from RAM before fast mode is raised
		fast = 1'b1;
		xfer(1'b0, 1'b1, 2'h2, 7);
		xfer(1'b0, 1'b1, 2'h1, 7);
		rest;
		chk(lat, 8'h09);
		chk({6'h00, raddr}, 8'h00);
		xfer(1'b1, 1'b1, 2'h3, 6);
		rest;
		chk(wrc, 8'h03);
		chk({6'h00, waddr}, 8'h00);
		// Single-word fast read: last comes with the first data word at N=5
		xfer(1'b0, 1'b1, 2'h2, 4);
		rest;
		chk({7'h00, oe_n}, 8'h01);
		chk(lat, 8'h0D);
		chk({6'h00, raddr}, 8'h01);
		// Pipelined flash access: strobe together with last keeps select on
		xfer(1'b0, 1'b1, 2'h0, 7);
		strobe_n = 1'b0;
		@(negedge sys_clk_i);
		strobe_n = 1'b1;
		last_n = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		chk({7'h00, cs_n}, 8'h00);
		last_n = 1'b0;
		rest;
		chk({7'h00, cs_n}, 8'h01);
		chk(lat, 8'h11);
		chk({6'h00, raddr}, 8'h03);
		end_sim;
	end
	// The sequence needs well under 200 clocks; this bound only catches a hang
	initial begin
		#20000;
		n_errors++;
		end_sim;
	end
endmodule
`default_nettype wire
